// File: inc/sbd_pkg.sv
// sbd_pkg: constants and carriers for the single-wire debug sync and breakpoint slice
// assumes one 40 MHz debug clock drives the whole block
package sbd_pkg;

  localparam int unsigned CLK_HZ         = 40_000_000;
  // request threshold: low time far beyond any normal debug bit
  localparam int unsigned SYNC_REQ_LOW   = 128;
  localparam int unsigned SLOW_CLK_DIV   = 64;
  localparam int unsigned REQ_LOW_CYCLES = SYNC_REQ_LOW * SLOW_CLK_DIV;
  localparam int unsigned HOLDOFF_CYCLES = 16;
  localparam int unsigned RESP_LOW       = 128;
  localparam int unsigned SPEEDUP_CYCLES = 1;
  localparam int unsigned CNT_W          = 14;

  localparam logic [CNT_W-1:0] REQ_LOW_CNT = CNT_W'(REQ_LOW_CYCLES);
  localparam logic [CNT_W-1:0] HOLDOFF_CNT = CNT_W'(HOLDOFF_CYCLES);
  localparam logic [CNT_W-1:0] RESP_CNT    = CNT_W'(RESP_LOW);
  localparam logic [CNT_W-1:0] SPEEDUP_CNT = CNT_W'(SPEEDUP_CYCLES);

  localparam int unsigned ADDR_W = 16;
  localparam logic [ADDR_W-1:0] BKPT_RST = 16'h0000;
  localparam logic SEL_FORCED = 1'b1;
  localparam logic SEL_TAGGED = 1'b0;

  typedef enum logic [4:0] {
    SBD_IDLE    = 5'b00001,
    SBD_WAIT_HI = 5'b00010,
    SBD_HOLDOFF = 5'b00100,
    SBD_RESP_LO = 5'b01000,
    SBD_SPEEDUP = 5'b10000
  } sbd_state_e;

  typedef struct packed {
    logic               enable;
    logic               force_tag_select;
    logic [ADDR_W-1:0]  match_value;
  } sbd_bkpt_cfg_s;

  typedef struct packed {
    logic [ADDR_W-1:0]  addr;
    logic               access;
    logic               opcode_fetch;
    logic               instr_boundary;
    logic               queue_end;
  } sbd_cpu_bus_s;

endpackage

// File: logic/sbd_bkpt.sv
// sbd_bkpt: single address-match breakpoint, forced or tagged
// assumes cpu bus strobes are synchronous to CLOCK
`timescale 1ns/10ps
`default_nettype none
module sbd_bkpt
  import sbd_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire sbd_bkpt_cfg_s cfg,
  input  wire sbd_cpu_bus_s  bus,
  output logic               background_req
);

  logic pend_q;
  logic tag_q;
  logic req_q;

  wire hit       = cfg.enable && (bus.addr == cfg.match_value) && bus.access;
  wire force_hit = hit && (cfg.force_tag_select == SEL_FORCED);
  wire tag_hit   = hit && bus.opcode_fetch && (cfg.force_tag_select == SEL_TAGGED);
  // forced: pending until the next instruction boundary
  wire force_fire = (pend_q || force_hit) && bus.instr_boundary;
  // tagged: fire when the marked opcode leaves the queue
  wire tag_fire   = tag_q && bus.queue_end;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= 1'b0;
      tag_q  <= 1'b0;
      req_q  <= 1'b0;
    end else begin
      pend_q <= cfg.enable && ((pend_q || force_hit) && !force_fire);
      tag_q  <= cfg.enable && ((tag_q && !tag_fire) || tag_hit);
      req_q  <= cfg.enable && (force_fire || tag_fire);
    end
  end

  assign background_req = req_q;

endmodule
`default_nettype wire

// File: logic/sbd_top.sv
// sbd_top: debug pin sync responder plus the simple hardware breakpoint
// assumes pin input is already synchronous to CLOCK; host keeps its own timing
`timescale 1ns/10ps
`default_nettype none
module sbd_top
  import sbd_pkg::*;
(
  input  wire logic              CLOCK,
  input  wire logic              RST_B,
  input  wire logic              DEBUG_PIN_I,
  output logic                   DEBUG_PIN_O,
  output logic                   DEBUG_PIN_OE,
  output logic                   SYNC_BUSY,
  input  wire logic              BKPT_ENABLE,
  input  wire logic              FORCE_TAG_SELECT,
  input  wire logic [ADDR_W-1:0] BKPT_MATCH_VALUE,
  input  wire logic [ADDR_W-1:0] CPU_ADDR,
  input  wire logic              CPU_ACCESS,
  input  wire logic              CPU_OPCODE_FETCH,
  input  wire logic              CPU_INSTR_BOUNDARY,
  input  wire logic              CPU_QUEUE_END,
  output logic                   BACKGROUND_REQ
);

  sbd_state_e       state_q;
  sbd_state_e       state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             pin_o_q;
  logic             pin_oe_q;
  logic             busy_q;
  logic             enable_q;
  logic             force_tag_q;
  logic [ADDR_W-1:0] match_q;

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (v == {CNT_W{1'b1}}) ? v : v + CNT_W'(1);
  endfunction

  function automatic logic reached(input logic [CNT_W-1:0] v, input logic [CNT_W-1:0] lim);
    reached = (v >= lim - CNT_W'(1));
  endfunction

  wire pin_low = !DEBUG_PIN_I;

  // one done decode per counted phase; the state machine only steers
  wire req_seen     = pin_low && reached(cnt_q, REQ_LOW_CNT);
  wire pin_back_hi  = !pin_low;
  wire holdoff_done = reached(cnt_q, HOLDOFF_CNT);
  wire resp_done    = reached(cnt_q, RESP_CNT);
  wire speedup_done = reached(cnt_q, SPEEDUP_CNT);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      SBD_IDLE: begin
        // count the low time; short lows are ordinary bits
        cnt_d = pin_low ? sat_inc(cnt_q) : '0;
        if (req_seen) begin
          state_d = SBD_WAIT_HI;
          cnt_d   = '0;
        end
      end
      SBD_WAIT_HI: begin
        if (pin_back_hi) begin
          state_d = SBD_HOLDOFF;
          cnt_d   = '0;
        end
      end
      SBD_HOLDOFF: begin
        cnt_d = sat_inc(cnt_q);
        if (holdoff_done) begin
          state_d = SBD_RESP_LO;
          cnt_d   = '0;
        end
      end
      SBD_RESP_LO: begin
        cnt_d = sat_inc(cnt_q);
        if (resp_done) begin
          state_d = SBD_SPEEDUP;
          cnt_d   = '0;
        end
      end
      SBD_SPEEDUP: begin
        cnt_d = sat_inc(cnt_q);
        if (speedup_done) begin
          state_d = SBD_IDLE;
          cnt_d   = '0;
        end
      end
      default: begin
        state_d = SBD_IDLE;
        cnt_d   = '0;
      end
    endcase
  end

  // pin drive registered from the next state so it lines up with the state
  wire nxt_low = (state_d == SBD_RESP_LO);
  wire nxt_hi  = (state_d == SBD_SPEEDUP);

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state_q  <= SBD_IDLE;
      cnt_q    <= '0;
      pin_o_q  <= 1'b1;
      pin_oe_q <= 1'b0;
      busy_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      pin_o_q  <= nxt_hi;
      pin_oe_q <= nxt_low || nxt_hi;
      busy_q   <= (state_d != SBD_IDLE);
    end
  end

  // settings captured once per cycle; enable clears on reset
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      enable_q    <= 1'b0;
      force_tag_q <= SEL_TAGGED;
      match_q     <= BKPT_RST;
    end else begin
      enable_q    <= BKPT_ENABLE;
      force_tag_q <= FORCE_TAG_SELECT;
      match_q     <= BKPT_MATCH_VALUE;
    end
  end

  wire sbd_bkpt_cfg_s cfg = '{enable: enable_q, force_tag_select: force_tag_q,
                              match_value: match_q};
  wire sbd_cpu_bus_s  bus = '{addr: CPU_ADDR, access: CPU_ACCESS,
                              opcode_fetch: CPU_OPCODE_FETCH,
                              instr_boundary: CPU_INSTR_BOUNDARY,
                              queue_end: CPU_QUEUE_END};

  sbd_bkpt u_bkpt (
    .clk            (CLOCK),
    .rst_b          (RST_B),
    .cfg            (cfg),
    .bus            (bus),
    .background_req (BACKGROUND_REQ)
  );

  assign DEBUG_PIN_O  = pin_o_q;
  assign DEBUG_PIN_OE = pin_oe_q;
  assign SYNC_BUSY    = busy_q;

endmodule
`default_nettype wire

// File: verification/sbd_chk_asserts.sv
// sbd_chk: timing checks on the sync responder and breakpoint ports
// assumes one CLOCK domain, RST_B async active low
`timescale 1ns/10ps
`default_nettype none
module sbd_chk (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic DEBUG_PIN_I,
  input wire logic DEBUG_PIN_O,
  input wire logic DEBUG_PIN_OE,
  input wire logic SYNC_BUSY,
  input wire logic BKPT_ENABLE,
  input wire logic CPU_INSTR_BOUNDARY,
  input wire logic CPU_QUEUE_END,
  input wire logic BACKGROUND_REQ
);
  logic [13:0] pin_lo_q;
  logic [7:0]  resp_lo_q;
  // run lengths, so exact counts need no long repetitions
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      pin_lo_q  <= 14'h0000;
      resp_lo_q <= 8'h00;
    end else begin
      pin_lo_q  <= DEBUG_PIN_I ? 14'h0000 : pin_lo_q + 14'h0001;
      resp_lo_q <= (DEBUG_PIN_OE && !DEBUG_PIN_O) ? resp_lo_q + 8'h01 : 8'h00;
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  chk_req_long: assert property ($rose(SYNC_BUSY) |-> pin_lo_q >= 14'h2000)
    else $error("busy without long low");
  chk_holdoff: assert property ($rose(DEBUG_PIN_OE) |-> $past(DEBUG_PIN_I, 17) && !$past(DEBUG_PIN_I, 18))
    else $error("holdoff wrong");
  chk_resp_low: assert property ($rose(DEBUG_PIN_OE) |-> !DEBUG_PIN_O)
    else $error("reply starts high");
  chk_resp_len: assert property (DEBUG_PIN_OE && DEBUG_PIN_O |-> resp_lo_q == 8'h80)
    else $error("reply low length");
  chk_speedup_one: assert property (DEBUG_PIN_OE && DEBUG_PIN_O |=> !DEBUG_PIN_OE)
    else $error("speedup too long");
  chk_idle_after: assert property ($fell(DEBUG_PIN_OE) |-> !SYNC_BUSY)
    else $error("not idle after release");
  chk_bkpt_off: assert property (!BKPT_ENABLE [*3] |=> !BACKGROUND_REQ)
    else $error("request while disabled");
  chk_req_cause: assert property (BACKGROUND_REQ |-> $past(CPU_INSTR_BOUNDARY || CPU_QUEUE_END))
    else $error("request without cause");
  cover property ($rose(SYNC_BUSY));
  cover property ($fell(DEBUG_PIN_OE));
  cover property (BACKGROUND_REQ);
endmodule
bind sbd_top sbd_chk u_chk (
  .CLOCK              (CLOCK),
  .RST_B              (RST_B),
  .DEBUG_PIN_I        (DEBUG_PIN_I),
  .DEBUG_PIN_O        (DEBUG_PIN_O),
  .DEBUG_PIN_OE       (DEBUG_PIN_OE),
  .SYNC_BUSY          (SYNC_BUSY),
  .BKPT_ENABLE        (BKPT_ENABLE),
  .CPU_INSTR_BOUNDARY (CPU_INSTR_BOUNDARY),
  .CPU_QUEUE_END      (CPU_QUEUE_END),
  .BACKGROUND_REQ     (BACKGROUND_REQ)
);
`default_nettype wire

// File: verification/sbd_host.sv
// sbd_host: debug host pod issuing sync requests and timing the reply
// assumes the bench resolves the pin with a pull-up
`timescale 1ns/10ps
`default_nettype none
module sbd_host (
  input  wire logic clk,
  input  wire logic pin,
  output var logic  oe,
  output var logic  o
);
  initial begin
    oe = 1'b0;
    o  = 1'b1;
  end
  task automatic sync(input int n, output int lo);
    lo = 0;
    oe = 1'b1;
    o  = 1'b0;
    repeat (n) @(posedge clk);
    #2 o = 1'b1;
    @(posedge clk);
    #2 oe = 1'b0;
    for (int t = 0; t < 300; t++) begin
      @(posedge clk);
      #2 lo += (pin === 1'b0);
    end
  endtask
endmodule
`default_nettype wire

// File: verification/tb_sbd_top.sv
// tb_sbd_top: host sync and cpu bus scenarios, self-checking
// assumes sbd_host on the pin and sbd_chk bound to the top
`timescale 1ns/10ps
`default_nettype none
module tb_sbd_top;
  logic clk = 1'b0, rst_b = 1'b0, en = 1'b0, fsel = 1'b0;
  logic [15:0] mv = 16'hA55A;
  logic acc = 1'b0, fe = 1'b0, ib = 1'b0, qe = 1'b0;
  logic [15:0] addr = 16'h0000;
  int num_errors = 0, check_count = 0, lo;
  wire pin_o, pin_oe, busy, req, h_oe, h_o;
  wire pin = pin_oe ? pin_o : (h_oe ? h_o : 1'b1);
  always #12.5 clk = ~clk;
  sbd_top DUT (.CLOCK(clk), .RST_B(rst_b), .DEBUG_PIN_I(pin), .DEBUG_PIN_O(pin_o),
    .DEBUG_PIN_OE(pin_oe), .SYNC_BUSY(busy), .BKPT_ENABLE(en), .FORCE_TAG_SELECT(fsel),
    .BKPT_MATCH_VALUE(mv), .CPU_ADDR(addr), .CPU_ACCESS(acc), .CPU_OPCODE_FETCH(fe),
    .CPU_INSTR_BOUNDARY(ib), .CPU_QUEUE_END(qe), .BACKGROUND_REQ(req));
  sbd_host host (.clk(clk), .pin(pin), .oe(h_oe), .o(h_o));
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %0t saw %h want %h", $time, s, e);
    end
  endtask
  task automatic summarize;
    if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic step;
    @(posedge clk);
    #2;
  endtask
  task automatic t_sync(input int n, input logic [15:0] exp);
    host.sync(n, lo);
    check(16'(lo), exp);
    check({15'h0000, busy}, 16'h0000);
  endtask
  // config, one access, then a boundary or queue-end pulse
  task automatic t_bk(input logic e, f, fetch, qend, input logic [15:0] a, input logic x);
    en = e;
    fsel = f;
    repeat (3) step;
    addr = a;
    acc = 1'b1;
    fe = fetch;
    step;
    acc = 1'b0;
    fe = 1'b0;
    ib = !qend;
    qe = qend;
    step;
    ib = 1'b0;
    qe = 1'b0;
    check({15'h0000, req}, {15'h0000, x});
    step;
    check({15'h0000, req}, 16'h0000);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #2 rst_b = 1'b1;
    check({12'h000, pin_o, pin_oe, busy, req}, 16'h0008);
    t_sync(8191, 16'h0000);
    t_sync(8192, 16'h0080);
    t_sync(8200, 16'h0080);
    t_bk(1'b1, 1'b1, 1'b0, 1'b0, 16'hA55A, 1'b1);
    t_bk(1'b1, 1'b1, 1'b0, 1'b0, 16'hA55B, 1'b0);
    t_bk(1'b1, 1'b0, 1'b1, 1'b1, 16'hA55A, 1'b1);
    t_bk(1'b1, 1'b0, 1'b0, 1'b1, 16'hA55A, 1'b0);
    t_bk(1'b1, 1'b0, 1'b1, 1'b0, 16'hA55A, 1'b0);
    t_bk(1'b0, 1'b1, 1'b0, 1'b0, 16'hA55A, 1'b0);
    mv = 16'h1234;
    t_bk(1'b1, 1'b1, 1'b0, 1'b0, 16'h1234, 1'b1);
    t_bk(1'b1, 1'b1, 1'b0, 1'b0, 16'hA55A, 1'b0);
    summarize;
  end
endmodule
`default_nettype wire
